// File: design/tfq_pkg.sv
// Purpose: shared constants and types for the trace frame qualifier
// Assumes: one frame per machine cycle, Avalon-MM register access
// Notes: row registers are laid out per set, per row, value then mask
package tfq_pkg;
	localparam int TFQ_ROWS = 10;
	localparam int TFQ_FRAME_W = 48;
	localparam int TFQ_DEPTH = 16;
	localparam int TFQ_ADDR_W = 10;
	// =====================================================
	// frame field positions
	localparam int TFQ_ADR_LSB = 0;
	localparam int TFQ_MSC_LSB = 16;
	localparam int TFQ_DAT_LSB = 24;
	localparam int TFQ_FPB_LSB = 32;
	localparam int TFQ_TPB_LSB = 40;
	// =====================================================
	// register byte offsets
	localparam logic [9:0] TFQ_OFF_CTRL = 10'h000;
	localparam logic [9:0] TFQ_OFF_STATUS = 10'h004;
	localparam logic [9:0] TFQ_OFF_POSTCNT = 10'h008;
	localparam logic [9:0] TFQ_OFF_LOOPCNT = 10'h00c;
	localparam logic [9:0] TFQ_OFF_ACTIVE = 10'h010;
	localparam logic [9:0] TFQ_OFF_ROWS = 10'h100;
	localparam logic [9:0] TFQ_ROW_STRIDE = 10'h010;
	localparam logic [9:0] TFQ_SET_STRIDE = 10'h0a0;
	// =====================================================
	// reset values
	localparam logic [15:0] TFQ_POSTCNT_RST = 16'h0800;
	localparam logic [15:0] TFQ_LOOPCNT_RST = 16'h0000;
	typedef enum logic [1:0] {
		TFQ_FILT_ALL = 2'h0,
		TFQ_FILT_A = 2'h1,
		TFQ_FILT_B = 2'h2,
		TFQ_FILT_AB = 2'h3
	} tfq_filt_t;
	typedef enum logic [2:0] {
		TFQ_TRG_DISABLED = 3'h0,
		TFQ_TRG_A = 3'h1,
		TFQ_TRG_B = 3'h2,
		TFQ_TRG_A_THEN_B = 3'h3,
		TFQ_TRG_A_LOOP = 3'h4,
		TFQ_TRG_LOOP_THEN_B = 3'h5
	} tfq_trg_t;
	typedef enum logic [1:0] {
		TFQ_ST_ARMED = 2'h0,
		TFQ_ST_WAIT_B = 2'h1,
		TFQ_ST_POST = 2'h2,
		TFQ_ST_STOP = 2'h3
	} tfq_state_t;
endpackage

// File: design/tfq_fifo.sv
// Purpose: small frame buffer between qualifier and trace store
// Assumes: single clock
// Notes: parameterised width and depth, depth a power of two
`timescale 1ns/100ps
module tfq_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr;
	logic [AW:0] rdPtr;
	logic full;
	logic empty;
	assign full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	assign empty = wrPtr == rdPtr;
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr[AW-1:0]];
	always_ff @(posedge clk) begin
		if (inValid && !full) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (inValid && !full) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (outReady && !empty) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end
endmodule

// File: design/tfq_trace_frame_qualifier.sv
// Purpose: qualify machine-cycle frames against A and B condition rows
// Assumes: frame pins asynchronous, one frameStrobe per machine cycle
// Notes: registers over Avalon-MM, stored frames leave through a FIFO
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - capture 48-bit frame each machine cycle
// - compare every frame against A and B
// - five fields per condition row
// - ten rows each for A and B
// - OR each field across rows of set
// - set true when all five ORs true
// - A and B evaluated independently, identically
// - cared bits must equal frame bits
// - masked bits match either value
// - filter stores on A, B, or A&B
// - filter defaults to store all frames
// - trigger defaults to disabled
// - trigger modes A, B, AthenB, loop variants
// - post-trigger frame count then stop
// - loop count sets A events needed
module tfq_trace_frame_qualifier
	import tfq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [tfq_pkg::TFQ_ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	input wire logic [15:0] addrPins,
	input wire logic [7:0] miscPins,
	input wire logic [7:0] dataPins,
	input wire logic [7:0] first_port_byte,
	input wire logic [7:0] third_port_byte,
	input wire logic frameStrobe,
	output logic aMatch,
	output logic bMatch,
	output logic storeFrame,
	output logic triggered,
	output logic traceStopped,
	output logic frameValid,
	input wire logic frameReady,
	output logic [tfq_pkg::TFQ_FRAME_W-1:0] frameData
);
	import tfq_pkg::*;
	// =====================================================
	// reset release and pin synchronisers
	logic [1:0] rstSync;
	logic rstnI;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstnI = rstSync[1];
	logic [TFQ_FRAME_W:0] pinRaw;
	logic [TFQ_FRAME_W:0] syn1;
	logic [TFQ_FRAME_W:0] syn2;
	logic [TFQ_FRAME_W:0] syn3;
	assign pinRaw = {frameStrobe, third_port_byte, first_port_byte, dataPins, miscPins, addrPins};
	always_ff @(posedge clk_sys or negedge rstnI) begin
		if (!rstnI) begin
			syn1 <= '0;
			syn2 <= '0;
			syn3 <= '0;
		end else begin
			syn1 <= pinRaw;
			syn2 <= syn1;
			syn3 <= syn2;
		end
	end
	// =====================================================
	// state
	typedef struct packed {
		logic [1:0][TFQ_ROWS-1:0][TFQ_FRAME_W-1:0] val;
		logic [1:0][TFQ_ROWS-1:0][TFQ_FRAME_W-1:0] msk;
		logic [1:0][TFQ_ROWS-1:0] active;
		tfq_filt_t filt;
		tfq_trg_t trg;
		logic [15:0] postCnt;
		logic [15:0] loopCnt;
		logic [TFQ_FRAME_W-1:0] frame;
		logic strbStable;
		logic cyc;
		tfq_state_t st;
		logic [15:0] loopSeen;
		logic [15:0] postLeft;
		logic restart;
		logic [31:0] rdata;
		logic rdDone;
		logic aHit;
		logic bHit;
		logic store;
		logic [31:0] drops;
	} tfq_regs_t;
	tfq_regs_t r;
	tfq_regs_t next_r;
	// =====================================================
	// condition matching per row, per field
	logic [1:0][TFQ_ROWS-1:0][4:0] fieldHit;
	logic [1:0][4:0] fieldOr;
	logic [1:0] setTrue;
	localparam int FLSB [5] = '{TFQ_ADR_LSB, TFQ_MSC_LSB, TFQ_DAT_LSB, TFQ_FPB_LSB, TFQ_TPB_LSB};
	localparam int FW [5] = '{16, 8, 8, 8, 8};
	genvar gs, gr, gf;
	generate
		for (gs = 0; gs < 2; gs++) begin : g_set
			for (gr = 0; gr < TFQ_ROWS; gr++) begin : g_row
				for (gf = 0; gf < 5; gf++) begin : g_fld
					// mask bit set means do not care
					assign fieldHit[gs][gr][gf] = r.active[gs][gr] &&
						(((r.frame[FLSB[gf] +: FW[gf]] ^ r.val[gs][gr][FLSB[gf] +: FW[gf]])
						& ~r.msk[gs][gr][FLSB[gf] +: FW[gf]]) == '0);
				end
			end
			for (gf = 0; gf < 5; gf++) begin : g_or
				always_comb begin
					fieldOr[gs][gf] = 1'b0;
					for (int i = 0; i < TFQ_ROWS; i++) begin
						fieldOr[gs][gf] = fieldOr[gs][gf] | fieldHit[gs][i][gf];
					end
				end
			end
			// same logic for A and B, no active row leaves all ORs low
			assign setTrue[gs] = &fieldOr[gs];
		end
	endgenerate
	// =====================================================
	// register decode
	logic [9:0] rowOff;
	logic rowSel;
	logic rowSet;
	logic [3:0] rowIdx;
	logic [1:0] rowWord;
	always_comb begin
		rowOff = avsAddress - TFQ_OFF_ROWS;
		rowSel = avsAddress >= TFQ_OFF_ROWS && avsAddress < TFQ_OFF_ROWS + 2 * TFQ_SET_STRIDE;
		rowSet = rowOff >= TFQ_SET_STRIDE;
		rowIdx = 4'((rowSet ? rowOff - TFQ_SET_STRIDE : rowOff) >> 4);
		rowWord = rowOff[3:2];
	end
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return m;
	endfunction
	// =====================================================
	// next state
	logic fifoReady;
	logic newCycle;
	logic trigHit;
	always_comb begin
		logic [31:0] cur;
		cur = 32'h0;
		next_r = r;
		next_r.strbStable = (syn2[TFQ_FRAME_W] == syn3[TFQ_FRAME_W]) ? syn3[TFQ_FRAME_W]
			: r.strbStable;
		newCycle = next_r.strbStable && !r.strbStable;
		next_r.cyc = newCycle;
		if (newCycle) begin
			next_r.frame = syn3[TFQ_FRAME_W-1:0];
		end
		// r.cyc marks the cycle whose frame is in r.frame
		next_r.aHit = r.cyc && setTrue[0];
		next_r.bHit = r.cyc && setTrue[1];
		trigHit = 1'b0;
		next_r.store = 1'b0;
		if (r.cyc && r.st != TFQ_ST_STOP) begin
			case (r.filt)
				TFQ_FILT_A: next_r.store = setTrue[0];
				TFQ_FILT_B: next_r.store = setTrue[1];
				TFQ_FILT_AB: next_r.store = setTrue[0] && setTrue[1];
				default: next_r.store = 1'b1;
			endcase
			if (next_r.store && !fifoReady) begin
				next_r.drops = r.drops + 32'h1;
			end
			case (r.st)
				TFQ_ST_ARMED: begin
					case (r.trg)
						TFQ_TRG_A: trigHit = setTrue[0];
						TFQ_TRG_B: trigHit = setTrue[1];
						TFQ_TRG_A_THEN_B: begin
							if (setTrue[0]) begin
								next_r.st = TFQ_ST_WAIT_B;
							end
						end
						TFQ_TRG_A_LOOP, TFQ_TRG_LOOP_THEN_B: begin
							if (setTrue[0]) begin
								next_r.loopSeen = r.loopSeen + 16'h1;
								if (r.loopSeen + 16'h1 >= r.loopCnt) begin
									if (r.trg == TFQ_TRG_A_LOOP) begin
										trigHit = 1'b1;
									end else begin
										next_r.st = TFQ_ST_WAIT_B;
									end
								end
							end
						end
						default: trigHit = 1'b0;
					endcase
				end
				TFQ_ST_WAIT_B: trigHit = setTrue[1];
				TFQ_ST_POST: begin
					next_r.postLeft = r.postLeft - 16'h1;
					if (r.postLeft <= 16'h1) begin
						next_r.st = TFQ_ST_STOP;
					end
				end
				default: next_r.st = r.st;
			endcase
			if (trigHit) begin
				next_r.st = (r.postCnt == 16'h0) ? TFQ_ST_STOP : TFQ_ST_POST;
				next_r.postLeft = r.postCnt;
			end
		end
		if (r.restart) begin
			next_r.st = TFQ_ST_ARMED;
			next_r.loopSeen = 16'h0;
		end
		next_r.restart = 1'b0;
		next_r.rdDone = 1'b0;
		if (avsRead && !r.rdDone) begin
			next_r.rdDone = 1'b1;
			next_r.rdata = 32'h0;
			if (rowSel) begin
				case (rowWord)
					2'h0: next_r.rdata = r.val[rowSet][rowIdx][31:0];
					2'h1: next_r.rdata = {16'h0, r.val[rowSet][rowIdx][47:32]};
					2'h2: next_r.rdata = r.msk[rowSet][rowIdx][31:0];
					default: next_r.rdata = {16'h0, r.msk[rowSet][rowIdx][47:32]};
				endcase
			end else begin
				case (avsAddress)
					TFQ_OFF_CTRL: next_r.rdata = {27'h0, r.trg, r.filt};
					// upper half counts frames lost to a full buffer
					TFQ_OFF_STATUS: next_r.rdata = {r.drops[15:0], 12'h0, r.st, r.bHit, r.aHit};
					TFQ_OFF_POSTCNT: next_r.rdata = {16'h0, r.postCnt};
					TFQ_OFF_LOOPCNT: next_r.rdata = {16'h0, r.loopCnt};
					TFQ_OFF_ACTIVE: next_r.rdata = {12'h0, r.active[1], r.active[0]};
					default: next_r.rdata = 32'h0;
				endcase
			end
		end
		if (avsWrite) begin
			if (rowSel) begin
				case (rowWord)
					2'h0: cur = r.val[rowSet][rowIdx][31:0];
					2'h1: cur = {16'h0, r.val[rowSet][rowIdx][47:32]};
					2'h2: cur = r.msk[rowSet][rowIdx][31:0];
					default: cur = {16'h0, r.msk[rowSet][rowIdx][47:32]};
				endcase
				cur = merge(cur, avsWriteData, avsByteEnable);
				case (rowWord)
					2'h0: next_r.val[rowSet][rowIdx][31:0] = cur;
					2'h1: next_r.val[rowSet][rowIdx][47:32] = cur[15:0];
					2'h2: next_r.msk[rowSet][rowIdx][31:0] = cur;
					default: next_r.msk[rowSet][rowIdx][47:32] = cur[15:0];
				endcase
			end else begin
				case (avsAddress)
					TFQ_OFF_CTRL: begin
						if (avsByteEnable[0]) begin
							next_r.filt = tfq_filt_t'(avsWriteData[1:0]);
							next_r.trg = tfq_trg_t'(avsWriteData[4:2]);
							next_r.restart = avsWriteData[8];
						end
					end
					TFQ_OFF_POSTCNT: begin
						cur = merge({16'h0, r.postCnt}, avsWriteData, avsByteEnable);
						next_r.postCnt = cur[15:0];
					end
					TFQ_OFF_LOOPCNT: begin
						cur = merge({16'h0, r.loopCnt}, avsWriteData, avsByteEnable);
						next_r.loopCnt = cur[15:0];
					end
					TFQ_OFF_ACTIVE: begin
						cur = merge({12'h0, r.active[1], r.active[0]}, avsWriteData,
							avsByteEnable);
						next_r.active = cur[19:0];
					end
					default: next_r.drops = next_r.drops;
				endcase
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rstnI) begin
		if (!rstnI) begin
			r <= '0;
			r.filt <= TFQ_FILT_ALL;
			r.trg <= TFQ_TRG_DISABLED;
			r.postCnt <= TFQ_POSTCNT_RST;
			r.loopCnt <= TFQ_LOOPCNT_RST;
			r.st <= TFQ_ST_ARMED;
		end else begin
			r <= next_r;
		end
	end
	// =====================================================
	// outputs; the fifo lets a slow store drain without a stall of the qualifier
	assign avsWaitRequest = avsRead && !r.rdDone;
	assign avsReadData = r.rdata;
	assign aMatch = r.aHit;
	assign bMatch = r.bHit;
	assign storeFrame = r.store;
	assign triggered = r.st == TFQ_ST_POST || r.st == TFQ_ST_STOP;
	assign traceStopped = r.st == TFQ_ST_STOP;
	logic [TFQ_FRAME_W-1:0] storedFrame;
	always_ff @(posedge clk_sys or negedge rstnI) begin
		if (!rstnI) begin
			storedFrame <= '0;
		end else if (r.cyc) begin
			storedFrame <= r.frame;
		end
	end
	tfq_fifo #(.WIDTH(TFQ_FRAME_W), .DEPTH(TFQ_DEPTH)) u_fifo (
		.clk(clk_sys),
		.rstn(rstnI),
		.inValid(r.store),
		.inReady(fifoReady),
		.inData(storedFrame),
		.outValid(frameValid),
		.outReady(frameReady),
		.outData(frameData)
	);
	// =====================================================
	// checks
	a_filter_all: assert property (@(posedge clk_sys) disable iff (!rstnI)
		r.cyc && r.filt == TFQ_FILT_ALL && r.st != TFQ_ST_STOP |=> storeFrame)
		else $error("frame not stored in all mode");
	a_filter_a: assert property (@(posedge clk_sys) disable iff (!rstnI)
		r.cyc && r.filt == TFQ_FILT_A && !setTrue[0] |=> !storeFrame)
		else $error("frame stored without A");
	a_a_match: assert property (@(posedge clk_sys) disable iff (!rstnI)
		r.cyc |=> aMatch == $past(setTrue[0]))
		else $error("A result not reported");
	a_no_active: assert property (@(posedge clk_sys) disable iff (!rstnI)
		r.active[0] == '0 |-> !setTrue[0])
		else $error("A true with no active row");
	a_no_trigger_select: assert property (@(posedge clk_sys) disable iff (!rstnI)
		r.trg == TFQ_TRG_DISABLED && r.st == TFQ_ST_ARMED && !r.restart |=> !triggered)
		else $error("trigger while disabled");
	a_b_trigger_select: assert property (@(posedge clk_sys) disable iff (!rstnI)
		r.cyc && r.st == TFQ_ST_ARMED && r.trg == TFQ_TRG_B && setTrue[1] && !r.restart
		&& r.postCnt != 16'h0 |=> r.st == TFQ_ST_POST)
		else $error("B trigger missed");
	sequence s_last_post;
		r.cyc && r.st == TFQ_ST_POST && r.postLeft == 16'h1 && !r.restart;
	endsequence
	a_post_stop: assert property (@(posedge clk_sys) disable iff (!rstnI)
		s_last_post |=> traceStopped)
		else $error("trace did not stop after count");
	a_b_indep: assert property (@(posedge clk_sys) disable iff (!rstnI)
		r.cyc |=> bMatch == $past(setTrue[1]))
		else $error("B result not reported");
endmodule

// File: verif/tfq_mcu_model.sv
// Purpose: far-side model presenting one frame per machine cycle
// Assumes: pins held 4 clocks either side of the strobe rise
// Notes: outside the hold window the pins carry the inverted frame
`timescale 1ns/100ps
module tfq_mcu_model (
	input wire logic clk,
	output logic [47:0] pins,
	output logic strobe
);
	initial begin
		pins = '0;
		strobe = 1'b0;
	end
	// ==========================================
	// one machine cycle
	task automatic cycle(input logic [47:0] f);
		@(posedge clk);
		pins <= f;
		repeat (4) @(posedge clk);
		strobe <= 1'b1;
		repeat (4) @(posedge clk);
		strobe <= 1'b0;
		// stale data inverted so a late capture is caught
		pins <= ~f;
	endtask
endmodule

// File: verif/tb_top.sv
// Purpose: self-checking bench for the trace frame qualifier
// Assumes: frame pins from the model, registers over Avalon-MM
// Notes: frames are popped from the buffer after each check
`timescale 1ns/100ps
module tb_top;
	import tfq_pkg::*;
	typedef struct packed {
		logic [1:0] filt;
		logic [47:0] f;
		logic a;
		logic b;
	} tfq_vec_t;
	localparam logic [47:0] FRAME_A = 48'h0011_0000_1234;
	localparam logic [47:0] FRAME_B = 48'h0000_a53c_9999;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [9:0] avsAddress = '0;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = '0;
	logic [31:0] avsReadData;
	logic avsWaitRequest;
	logic [47:0] pins;
	logic frameStrobe;
	logic aMatch, bMatch, storeFrame, triggered, traceStopped, frameValid;
	logic frameReady = 1'b0;
	logic [47:0] frameData;
	logic [31:0] rd;
	int num_errors = 0;
	int n_tests = 0;
	int aCnt = 0;
	int bCnt = 0;
	int sCnt = 0;
	int trigAt [6] = '{0, 1, 2, 2, 3, 4};
	tfq_vec_t vecs [9] = '{
		'{2'h0, 48'h0011_0000_1234, 1'b1, 1'b0},
		'{2'h1, 48'h0022_0000_1234, 1'b1, 1'b0},
		'{2'h1, 48'h0033_0000_1234, 1'b0, 1'b0},
		'{2'h1, 48'h0011_0000_1235, 1'b0, 1'b0},
		'{2'h2, 48'h0000_a53c_9999, 1'b0, 1'b1},
		'{2'h2, 48'h0000_b53c_0000, 1'b0, 1'b0},
		'{2'h3, 48'h5511_a73c_5678, 1'b1, 1'b1},
		'{2'h3, 48'h0011_0000_1234, 1'b1, 1'b0},
		'{2'h0, 48'h0000_af3d_0000, 1'b0, 1'b0}
	};
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		aCnt <= aCnt + int'(aMatch === 1'b1);
		bCnt <= bCnt + int'(bMatch === 1'b1);
		sCnt <= sCnt + int'(storeFrame === 1'b1);
	end
	tfq_trace_frame_qualifier u_dut (
		.clk_sys(clk_sys), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead),
		.avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hf),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
		.addrPins(pins[15:0]), .miscPins(pins[23:16]), .dataPins(pins[31:24]),
		.first_port_byte(pins[39:32]), .third_port_byte(pins[47:40]),
		.frameStrobe(frameStrobe), .aMatch(aMatch), .bMatch(bMatch),
		.storeFrame(storeFrame), .triggered(triggered), .traceStopped(traceStopped),
		.frameValid(frameValid), .frameReady(frameReady), .frameData(frameData)
	);
	tfq_mcu_model u_mcu (.clk(clk_sys), .pins(pins), .strobe(frameStrobe));
	// ==========================================
	// helpers
	task automatic print_verdict();
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avsWaitRequest !== 1'b0 && k < 50);
		rd = avsReadData;
		chk(k < 50, "bus hang");
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	task automatic rdChk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk((rd & m) === e, "register value");
	endtask
	task automatic setRow(input int s, input int r, input logic [47:0] v, input logic [47:0] m);
		logic [9:0] b;
		b = TFQ_OFF_ROWS + 10'(s) * TFQ_SET_STRIDE + 10'(r) * TFQ_ROW_STRIDE;
		bus(1'b1, b, v[31:0]);
		bus(1'b1, b + 10'h004, {16'h0000, v[47:32]});
		bus(1'b1, b + 10'h008, m[31:0]);
		bus(1'b1, b + 10'h00c, {16'h0000, m[47:32]});
	endtask
	task automatic pop();
		frameReady <= 1'b1;
		@(posedge clk_sys);
		frameReady <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic drain();
		repeat (20) begin
			if (frameValid === 1'b1) pop();
		end
	endtask
	task automatic frame(input logic [47:0] f);
		u_mcu.cycle(f);
		// sync, compare and buffer latency all fit in this span
		repeat (12) @(posedge clk_sys);
	endtask
	task automatic run(input logic [47:0] f, input logic ea, input logic eb, input logic es);
		int a0, b0, s0;
		a0 = aCnt;
		b0 = bCnt;
		s0 = sCnt;
		frame(f);
		chk(aCnt - a0 == int'(ea), "a result");
		chk(bCnt - b0 == int'(eb), "b result");
		chk(sCnt - s0 == int'(es), "store decision");
		chk(frameValid === es, "buffer valid");
		if (es) begin
			chk(frameData === f, "frame data");
			pop();
		end
	endtask
	// ==========================================
	// main sequence
	initial begin
		// whole run is near 1250 cycles, so this only cuts a hang
		repeat (40000) @(posedge clk_sys);
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		setRow(0, 0, 48'h0011_0000_1234, 48'hff00_ffff_0000);
		setRow(0, 1, 48'h0022_0000_5678, 48'hff00_ffff_0000);
		setRow(0, 2, 48'h0, 48'hffff_ffff_ffff);
		setRow(1, 9, 48'h0000_a03c_0000, 48'hffff_0f00_ffff);
		bus(1'b1, TFQ_OFF_ACTIVE, 32'h0008_0003);
		rdChk(TFQ_OFF_ROWS + 10'h008, 32'hffff_ffff, 32'hffff_0000);
		rdChk(TFQ_OFF_ROWS + TFQ_SET_STRIDE + 10'h090, 32'hffff_ffff, 32'ha03c_0000);
		rdChk(10'h3fc, 32'hffff_ffff, 32'h0);
		foreach (vecs[i]) begin
			bus(1'b1, TFQ_OFF_CTRL, {30'h0, vecs[i].filt});
			run(vecs[i].f, vecs[i].a, vecs[i].b,
				(!vecs[i].filt[0] || vecs[i].a) && (!vecs[i].filt[1] || vecs[i].b));
			chk(triggered === 1'b0, "trigger while disabled");
		end
		$display("test table done");
		bus(1'b1, TFQ_OFF_POSTCNT, 32'h100);
		bus(1'b1, TFQ_OFF_LOOPCNT, 32'h2);
		for (int m = 1; m <= 5; m++) begin
			bus(1'b1, TFQ_OFF_CTRL, 32'h100 | 32'(m << 2));
			for (int k = 1; k <= 4; k++) begin
				frame(k[0] ? FRAME_A : FRAME_B);
				chk(triggered === (k >= trigAt[m]), "trigger moment");
			end
			chk(traceStopped === 1'b0, "early stop");
			drain();
		end
		bus(1'b1, TFQ_OFF_POSTCNT, 32'h1);
		bus(1'b1, TFQ_OFF_CTRL, 32'h104);
		frame(FRAME_A);
		chk(triggered === 1'b1, "no trigger");
		frame(FRAME_B);
		chk(traceStopped === 1'b1, "no stop");
		rdChk(TFQ_OFF_STATUS, 32'hc, 32'hc);
		drain();
		$display("test trigger done");
		bus(1'b1, TFQ_OFF_CTRL, 32'h100);
		for (int i = 1; i <= 17; i++) frame(48'(i));
		for (int i = 1; i <= TFQ_DEPTH; i++) begin
			chk(frameValid === 1'b1 && frameData === 48'(i), "buffer order");
			pop();
		end
		chk(frameValid === 1'b0, "buffer overfilled");
		rdChk(TFQ_OFF_STATUS, 32'hffff_0000, 32'h0001_0000);
		$display("test buffer done");
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(frameValid === 1'b0 && triggered === 1'b0, "outputs in reset");
		rstn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rdChk(TFQ_OFF_CTRL, 32'h1f, 32'h0);
		rdChk(TFQ_OFF_POSTCNT, 32'hffff, 32'h800);
		rdChk(TFQ_OFF_LOOPCNT, 32'hffff, 32'h0);
		rdChk(TFQ_OFF_ACTIVE, 32'hfffff, 32'h0);
		run(FRAME_A, 1'b0, 1'b0, 1'b1);
		$display("test reset done");
		print_verdict();
	end
endmodule
